// [logic/tca_pkg.sv]
// Operation
// RULE1: Sample data on each rising serial clock
// RULE2: Shift only while strobe is low
// RULE3: Chain output carries previous register bits
// RULE4: Controller raises strobe after all bits shifted
// RULE5: Strobe low before first edge, whole frame
// RULE6: Frame is address byte plus attenuation byte
// RULE7: Both bytes sent most significant bit first
// RULE8: Address byte comes first in frame
// RULE9: Only recognised address changes one channel
// RULE10: Set addressed channel to encoded level
// RULE11: Codes 0x4f to 0xff mute the channel
// RULE12: All channels muted at power up (code mutes them at the first link clock edge, outputs undefined before it)
// RULE13: Mute accepted from any previous setting
// RULE14: Latch frame when strobe goes high
// RULE15: Address 0,1,2 select channels one to three
// RULE16: Codes step 0.5, 1, 2 dB bands
// RULE17: Chain of n devices shifts 16n bits
// RULE18: Unknown address leaves every channel unchanged
package tca_pkg;

  // ----------------------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------------------
  localparam int unsigned FRAME_BITS = 16;
  localparam int unsigned BYTE_BITS  = 8;
  localparam int unsigned NUM_CH     = 3;
  localparam int unsigned ADDR_MSB   = 15;
  localparam int unsigned ADDR_LSB   = 8;
  localparam int unsigned CODE_MSB   = 7;
  localparam int unsigned CODE_LSB   = 0;
  localparam int unsigned CNT_W      = 5;

  // ----------------------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------------------
  localparam logic [7:0] ADDR_CH1      = 8'h00;
  localparam logic [7:0] ADDR_CH2      = 8'h01;
  localparam logic [7:0] ADDR_CH3      = 8'h02;
  localparam logic [7:0] CODE_BAND1_HI = 8'h1f;
  localparam logic [7:0] CODE_BAND2_HI = 8'h3f;
  localparam logic [7:0] CODE_MAX      = 8'h4e;
  localparam logic [7:0] CODE_MUTE_LO  = 8'h4f;
  localparam logic [7:0] CODE_MUTE     = 8'hff;
  // Level in half-dB units (76 dB -> 152), mute flag separate
  localparam logic [7:0] HDB_BAND2_BASE = 8'h20;
  localparam logic [7:0] HDB_BAND3_BASE = 8'h60;
  localparam logic [7:0] HDB_RST        = 8'h00;

  // ----------------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------------
  localparam int unsigned MCLK_MHZ      = 125;
  localparam int unsigned SETUP_NS      = 150;
  localparam int unsigned SETUP_CYC     = (SETUP_NS * MCLK_MHZ + 999) / 1000;
  localparam int unsigned DIV_HALF      = 4;
  localparam logic [7:0]  FRAME_RST     = 8'h00;

endpackage : tca_pkg

// [logic/tca_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface tca_if;
  logic sclk;
  logic load_shift;
  logic sdata_in;
  logic sdata_out;

  modport dev (input sclk, input load_shift, input sdata_in, output sdata_out);
  modport ctl (output sclk, output load_shift, output sdata_in, input sdata_out);
endinterface : tca_if
`default_nettype wire

// [logic/tca_dev.sv]
`timescale 1ns/1ps
`default_nettype none
module tca_dev
  import tca_pkg::*;
(
  tca_if.dev                 lnk,
  output logic [NUM_CH-1:0]  ch_mute,
  output logic [7:0]         ch_hdb [NUM_CH],
  output logic [NUM_CH-1:0]  ch_code_valid
);

  // ----------------------------------------------------------------------------
  // Shift register on the link clock
  // ----------------------------------------------------------------------------
  logic [FRAME_BITS-1:0] sr_q;
  logic [FRAME_BITS-1:0] latch_q;
  logic                  ld_q;
  logic                  upd_q;
  logic                  pwr_q = 1'b0;

  always_ff @(posedge lnk.sclk) begin
    if (!lnk.load_shift) begin // RULE2
      sr_q <= {sr_q[FRAME_BITS-2:0], lnk.sdata_in}; // RULE1 RULE7 RULE8
    end
  end

  // Oldest bit leaves straight from the register, so chained devices form one long register
  assign lnk.sdata_out = sr_q[FRAME_BITS-1]; // RULE3

  // Strobe rise seen at next link edge latches the frame
  always_ff @(posedge lnk.sclk) begin
    ld_q  <= lnk.load_shift;
    upd_q <= lnk.load_shift && !ld_q; // RULE14
    if (lnk.load_shift && !ld_q) begin
      latch_q <= sr_q; // RULE14 RULE6
    end
  end

  // ----------------------------------------------------------------------------
  // Channel decode, one instance per channel
  // ----------------------------------------------------------------------------
  logic [7:0] addr;
  logic [7:0] code;
  assign addr = latch_q[ADDR_MSB:ADDR_LSB];
  assign code = latch_q[CODE_MSB:CODE_LSB];

  function automatic logic [7:0] to_hdb(input logic [7:0] c);
    if (c <= CODE_BAND1_HI) begin
      return c; // RULE16
    end else if (c <= CODE_BAND2_HI) begin
      return 8'((c - 8'h20) << 1) + HDB_BAND2_BASE;
    end else begin
      return 8'((c - 8'h40) << 2) + HDB_BAND3_BASE;
    end
  endfunction

  always_ff @(posedge lnk.sclk) begin
    pwr_q <= 1'b1;
  end

  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    logic [7:0] sel;
    assign sel = 8'(i); // RULE15
    always_ff @(posedge lnk.sclk) begin
      if (!pwr_q) begin
        ch_mute[i]       <= 1'b1; // RULE12
        ch_hdb[i]        <= HDB_RST;
        ch_code_valid[i] <= 1'b0;
      end else if (upd_q && addr == sel) begin // RULE9 RULE18
        ch_code_valid[i] <= 1'b1;
        if (code >= CODE_MUTE_LO) begin
          ch_mute[i] <= 1'b1; // RULE11 RULE13
        end else begin
          ch_mute[i] <= 1'b0;
          ch_hdb[i]  <= to_hdb(code); // RULE10
        end
      end
    end
  end

endmodule : tca_dev
`default_nettype wire

// [logic/tca_ctl.sv]
`timescale 1ns/1ps
`default_nettype none
module tca_ctl
  import tca_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  tca_if.ctl               lnk,
  input  wire logic        req_valid,
  input  wire logic [15:0] req_frame,
  output logic             req_ready,
  output logic             done
);

  typedef enum {ST_IDLE, ST_SETUP, ST_LOW, ST_HIGH, ST_LOAD, ST_LATCH, ST_GAP, ST_APPLY} tca_st_e;
  tca_st_e      st_q;
  logic [15:0]  sh_q;
  logic [CNT_W-1:0] bit_q;
  logic [7:0]   cnt_q;
  logic         sclk_q;
  logic         ls_q;
  logic         sd_q;

  assign lnk.sclk       = sclk_q;
  assign lnk.load_shift = ls_q;
  assign lnk.sdata_in   = sd_q;

  // ----------------------------------------------------------------------------
  // Frame sequencer: clock made by divider, MSB first
  // ----------------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_q <= ST_IDLE;
      sh_q <= 16'h0000;
      bit_q <= '0;
      cnt_q <= 8'h00;
      sclk_q <= 1'b0;
      ls_q <= 1'b1;
      sd_q <= 1'b0;
      req_ready <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      req_ready <= (st_q == ST_IDLE) && !req_valid;
      case (st_q)
        ST_IDLE: begin
          req_ready <= 1'b1;
          if (req_valid && req_ready) begin
            req_ready <= 1'b0;
            sh_q <= req_frame;
            ls_q <= 1'b0; // RULE5
            sd_q <= req_frame[15]; // RULE7
            cnt_q <= 8'(SETUP_CYC);
            bit_q <= '0;
            st_q <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          if (cnt_q == 8'h00) begin
            st_q <= ST_HIGH;
            cnt_q <= 8'(DIV_HALF - 1);
            sclk_q <= 1'b1; // RULE1
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        ST_HIGH: begin
          if (cnt_q == 8'h00) begin
            sclk_q <= 1'b0;
            bit_q <= bit_q + 5'h01;
            sh_q <= {sh_q[14:0], 1'b0};
            sd_q <= sh_q[14]; // RULE8
            cnt_q <= 8'(DIV_HALF - 1);
            st_q <= (bit_q == 5'(FRAME_BITS - 1)) ? ST_LOAD : ST_LOW; // RULE6
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        ST_LOW: begin
          if (cnt_q == 8'h00) begin
            sclk_q <= 1'b1;
            cnt_q <= 8'(DIV_HALF - 1);
            st_q <= ST_HIGH;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        ST_LOAD: begin
          // Strobe rises alone, never on a link clock edge, so the device sees it settled
          if (cnt_q == 8'h00) begin
            ls_q <= 1'b1; // RULE4 RULE17
            cnt_q <= 8'(DIV_HALF - 1);
            st_q <= ST_LATCH;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        ST_LATCH: begin
          // First edge with strobe high latches the frame
          if (cnt_q == 8'h00) begin
            sclk_q <= 1'b1; // RULE14
            cnt_q <= 8'(DIV_HALF - 1);
            st_q <= ST_GAP;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        ST_GAP: begin
          if (cnt_q == 8'h00) begin
            sclk_q <= 1'b0;
            cnt_q <= 8'(DIV_HALF - 1);
            st_q <= ST_APPLY;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        ST_APPLY: begin
          // Second edge with strobe high applies the latched frame to the channels
          if (cnt_q == 8'h00) begin
            sclk_q <= 1'b1; // RULE14
            st_q <= ST_IDLE;
            done <= 1'b1;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
      if (st_q == ST_IDLE && sclk_q) begin
        sclk_q <= 1'b0;
      end
    end
  end

endmodule : tca_ctl
`default_nettype wire

// [tb/tca_link_props.sv]
`timescale 1ns/1ps
`default_nettype none
module tca_link_props (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic sclk,
  input wire logic load_shift,
  input wire logic sdata_in,
  input wire logic sdata_out,
  input wire logic done
);
  logic [4:0] cnt_q;
  logic       sclk_q;
  always_ff @(posedge mclk) begin
    sclk_q <= sclk;
  end
  always_ff @(posedge mclk) begin
    if (load_shift) cnt_q <= 5'h00;
    else if (sclk && !sclk_q) cnt_q <= cnt_q + 5'h01;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sequence s_gap; (!$rose(sclk)) throughout (1'b1 ##18 1'b1); endsequence
  sequence s_high; sclk [*4] ##1 !sclk; endsequence
  sequence s_latch;
    (load_shift && !sclk) [*4] ##1 (load_shift && $rose(sclk));
  endsequence
  property p_setup; $fell(load_shift) |-> s_gap; endproperty
  property p_count; $rose(load_shift) |-> cnt_q == 5'h10; endproperty
  property p_hold; (!load_shift && cnt_q != 5'h10) |=> !load_shift; endproperty
  property p_stable; (sclk && !load_shift) |-> $stable(sdata_in); endproperty
  property p_period; ($rose(sclk) && !load_shift) |-> s_high; endproperty
  property p_chain; $changed(sdata_out) |-> $rose(sclk); endproperty
  property p_latch; $rose(load_shift) |-> s_latch; endproperty
  property p_apply; done |-> $rose(sclk) && load_shift; endproperty
  property p_pulse; done |=> !done; endproperty
  a_setup: assert property (p_setup) else $error("strobe setup short");
  a_count: assert property (p_count) else $error("frame not 16 bits");
  a_hold: assert property (p_hold) else $error("strobe rose early");
  a_stable: assert property (p_stable) else $error("data moved");
  a_period: assert property (p_period) else $error("clock shape");
  a_chain: assert property (p_chain) else $error("chain out moved");
  a_latch: assert property (p_latch) else $error("latch edge misplaced");
  a_apply: assert property (p_apply) else $error("done off apply edge");
  a_pulse: assert property (p_pulse) else $error("done too long");
endmodule // tca_link_props
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import tca_pkg::*;
  logic mclk, sys_rst, req_valid, req_ready, done, seen;
  logic [15:0] req_frame, rx, tx, prev;
  logic [NUM_CH-1:0] ch_mute, ch_code_valid, exp_mute, known, exp_valid;
  logic [7:0] ch_hdb [NUM_CH];
  logic [7:0] exp_hdb [NUM_CH];
  int error_cnt, checked;
  tca_if tca_if_inst ();
  tca_dev tca_dev_inst (.lnk(tca_if_inst), .ch_mute(ch_mute), .ch_hdb(ch_hdb),
    .ch_code_valid(ch_code_valid));
  tca_ctl tca_ctl_inst (.mclk(mclk), .sys_rst(sys_rst), .lnk(tca_if_inst),
    .req_valid(req_valid), .req_frame(req_frame), .req_ready(req_ready), .done(done));
  tca_link_props tca_link_props_inst (.mclk(mclk), .sys_rst(sys_rst),
    .sclk(tca_if_inst.sclk), .load_shift(tca_if_inst.load_shift),
    .sdata_in(tca_if_inst.sdata_in), .sdata_out(tca_if_inst.sdata_out), .done(done));
  // ----------------------------------------
  // Wire capture and checks
  // ----------------------------------------
  always @(posedge tca_if_inst.sclk) if (!tca_if_inst.load_shift) begin
    rx = {rx[14:0], tca_if_inst.sdata_in};
    tx = {tx[14:0], tca_if_inst.sdata_out};
  end
  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t wire %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_ch(input int i);
    checked++;
    if (ch_mute[i] !== exp_mute[i] || ch_code_valid[i] !== exp_valid[i] ||
        (known[i] && ch_hdb[i] !== exp_hdb[i])) begin
      error_cnt++;
      $display("[FAIL] %0t ch %0d mute %b level %h written %b", $time, i, ch_mute[i],
        ch_hdb[i], ch_code_valid[i]);
    end
  endtask
  task automatic send(input logic [15:0] f);
    int n;
    n = 0;
    do begin @(posedge mclk); #1; n++; end while (req_ready !== 1'b1 && n < 400);
    if (n >= 400) begin
      error_cnt++;
      $display("[FAIL] %0t ready timeout", $time);
    end
    req_valid = 1'b1;
    req_frame = f;
    @(posedge mclk);
    #1 req_valid = 1'b0;
    n = 0;
    do begin @(posedge mclk); #1; n++; end while (done !== 1'b1 && n < 400);
    if (n >= 400) begin
      error_cnt++;
      $display("[FAIL] %0t done timeout", $time);
    end
    cmp_word(rx, f);
    if (seen) cmp_word(tx, prev);
    seen = 1'b1;
    prev = f;
  endtask
  // Each write is checked as soon as done; an unknown-address frame must then change nothing
  task automatic put(input logic [7:0] a, input logic [7:0] c, input logic [7:0] lvl);
    send({a, c});
    if (a < 8'h03) begin
      exp_valid[a] = 1'b1;
      exp_mute[a] = (c >= CODE_MUTE_LO);
      if (c < CODE_MUTE_LO) begin
        exp_hdb[a] = lvl;
        known[a] = 1'b1;
      end
    end
    for (int i = 0; i < NUM_CH; i++) cmp_ch(i);
    send(16'h0300);
    for (int i = 0; i < NUM_CH; i++) cmp_ch(i);
  endtask
  task automatic t_power;
    put(8'h05, 8'h00, 8'h00);
  endtask
  // Levels in half-dB units: 15.5, 16, 47, 48 and 76 dB at the band edges
  task automatic t_levels;
    logic [7:0] lv [6];
    logic [7:0] hv [6];
    lv = '{8'h00, 8'h1f, 8'h20, 8'h3f, 8'h40, 8'h4e};
    hv = '{8'h00, 8'h1f, 8'h20, 8'h5e, 8'h60, 8'h98};
    for (int a = 0; a < 3; a++) for (int k = 0; k < 6; k++) put(8'(a), lv[k], hv[k]);
  endtask
  task automatic t_mute;
    put(8'h00, 8'h4f, 8'h00);
    put(8'h01, 8'hff, 8'h00);
    put(8'h02, 8'h80, 8'h00);
    put(8'h02, 8'h10, 8'h10);
  endtask
  task automatic stop_test;
    if (error_cnt == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  initial begin
    #200000;
    error_cnt++;
    stop_test;
  end
  initial begin
    sys_rst = 1'b1;
    req_valid = 1'b0;
    req_frame = 16'h0000;
    exp_mute = '1;
    known = '0;
    exp_valid = '0;
    seen = 1'b0;
    repeat (16) @(posedge mclk);
    #1 sys_rst = 1'b0;
    t_power;
    t_levels;
    t_mute;
    stop_test;
  end
endmodule // tb_top
`default_nettype wire
